// ---- nmc_ctrl.sv ----
// Host controller driving a NAND flash through its strobe pins
`timescale 1ns/1ps
module nmc_ctrl (
  input wire logic clk,                    // 250 MHz clock
  input wire logic nrst,                   // Async reset, active low
  input wire logic req_valid,              // Request valid
  output logic req_ready,                  // Request taken
  input wire nmc_pkg::nmc_op_t req_op,     // Cycle kind
  input wire logic [7:0] req_data,         // Command, address or data byte
  output logic rsp_valid,                  // Read byte or wait done, one pulse
  output logic [7:0] rsp_data,             // Read byte
  output logic refused,                    // Request refused, one pulse
  output logic [3:0] plane_fail,           // Per-plane fail from last 71h read showing ready
  output logic status_ok_valid,            // Plane results may be trusted
  output logic init_done,                  // Power-up wait over
  output logic chip_en_n,                  // Chip enable, active low
  output logic cmd_latch,                  // Command latch enable
  output logic addr_latch,                 // Address latch enable
  output logic write_strobe_n,             // Write strobe, active low
  output logic read_strobe_low,            // Read strobe, active low
  output logic [7:0] io_out,               // I/O lines driven value
  output logic io_oe_n,                    // I/O enable, low while driving
  input wire logic [7:0] io_in,            // I/O lines sampled
  input wire logic ready_busy_n            // Open-drain ready/busy, low busy
);
  import nmc_pkg::*;

  typedef enum logic [5:0] {
    NMC_S_PWR = 6'b000001,
    NMC_S_IDLE = 6'b000010,
    NMC_S_WLOW = 6'b000100,
    NMC_S_WHIGH = 6'b001000,
    NMC_S_RLOW = 6'b010000,
    NMC_S_WAIT = 6'b100000
  } nmc_state_t;

  nmc_state_t state_r, state_nxt;
  logic [12:0] cnt_r;
  logic [7:0] last_cmd_r;
  logic [7:0] io_out_r, rsp_data_r;
  logic cle_r, ale_r, rsp_v_r, in_reset_r, mp_busy_r;
  logic [3:0] plane_fail_r;
  logic st_valid_r;
  logic [2:0] erase_cnt_r;
  logic mp_status_r;

  // Decode of incoming request
  wire is_cmd = req_op == NMC_OP_CMD;
  wire cmd_status = req_data == NMC_CMD_STATUS || req_data == NMC_CMD_STATUS_MP;
  wire cmd_reset = req_data == NMC_CMD_RESET;
  wire cmd_status_last = last_cmd_r == NMC_CMD_STATUS || last_cmd_r == NMC_CMD_STATUS_MP;
  // Device busy ignores all but status and reset, so refuse here instead; waits and
  // status reads must still pass, or the lock could never be released
  wire busy_ok = req_op == NMC_OP_WAIT || (req_op == NMC_OP_RDATA && cmd_status_last)
                 || (is_cmd && (cmd_status || cmd_reset));
  wire busy_block = mp_busy_r && !busy_ok;
  // Repeat reset while still resetting would be dropped by the device
  wire dup_reset = is_cmd && cmd_reset && in_reset_r;
  // Fifth erase setup exceeds the plane count
  wire erase_over = is_cmd && req_data == NMC_CMD_ERASE_SETUP
                    && erase_cnt_r == 3'(NMC_PLANES);
  wire reject = busy_block || dup_reset || erase_over;
  wire take = state_r == NMC_S_IDLE && req_valid;
  wire cnt_done = cnt_r == '0;
  // Only real programs and erases lock the command set; 11h leaves it open
  wire locks_cmd = is_cmd && (req_data == NMC_CMD_PROG
                   || req_data == NMC_CMD_ERASE_CONF);

  assign req_ready = take;
  assign init_done = state_r != NMC_S_PWR;

  // Next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      NMC_S_PWR: if (cnt_done) state_nxt = NMC_S_IDLE;
      NMC_S_IDLE: begin
        if (take && !reject) begin
          if (req_op == NMC_OP_WAIT) state_nxt = NMC_S_WAIT;
          else if (req_op == NMC_OP_RDATA) state_nxt = NMC_S_RLOW;
          else state_nxt = NMC_S_WLOW;
        end
      end
      NMC_S_WLOW: if (cnt_done) state_nxt = NMC_S_WHIGH;
      NMC_S_WHIGH: if (cnt_done) state_nxt = NMC_S_IDLE;
      NMC_S_RLOW: if (cnt_done) state_nxt = NMC_S_IDLE;
      NMC_S_WAIT: if (cnt_done && ready_busy_n) state_nxt = NMC_S_IDLE;
      default: state_nxt = NMC_S_IDLE;
    endcase
  end

  // State and cycle counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= NMC_S_PWR;
      cnt_r <= 13'(NMC_POWERUP_CYC);
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        // Strobe count loads one short: the entry edge is already the first phase cycle
        cnt_r <= (state_nxt == NMC_S_WAIT) ? 13'(NMC_BUSY_LAT_CYC) : 13'(NMC_STROBE_CYC - 1);
      end else if (!cnt_done) begin
        cnt_r <= cnt_r - 13'd1;
      end
    end
  end

  // Latch the byte and its kind when a request is taken and not refused; bytes pass unaltered, so
  // command order, plane choice, pointer use and data correction stay with the user
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      io_out_r <= '0;
      cle_r <= 1'b0;
      ale_r <= 1'b0;
    end else if (take && !reject) begin
      io_out_r <= req_data;
      cle_r <= is_cmd;
      ale_r <= req_op == NMC_OP_ADDR;
    end else if (state_r == NMC_S_IDLE) begin
      cle_r <= 1'b0;
      ale_r <= 1'b0;
    end
  end

  // Command tracking: busy window, reset state, erase count, status mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_cmd_r <= NMC_CMD_READ0;
      in_reset_r <= 1'b0;
      mp_busy_r <= 1'b0;
      erase_cnt_r <= '0;
      mp_status_r <= 1'b0;
    end else if (take && !reject && is_cmd) begin
      last_cmd_r <= req_data;
      in_reset_r <= cmd_reset;
      // Status reads keep the lock; reset drops it with the aborted operation
      if (!cmd_status) mp_busy_r <= locks_cmd;
      if (req_data == NMC_CMD_ERASE_SETUP) erase_cnt_r <= erase_cnt_r + 3'd1;
      else if (!cmd_status) erase_cnt_r <= '0;
      if (cmd_status) mp_status_r <= req_data == NMC_CMD_STATUS_MP;
    end else if (state_r == NMC_S_WAIT && state_nxt == NMC_S_IDLE) begin
      mp_busy_r <= 1'b0;
    end
  end

  // Strobe phase outputs
  assign chip_en_n = state_r == NMC_S_PWR;
  assign cmd_latch = cle_r && (state_r == NMC_S_WLOW || state_r == NMC_S_WHIGH);
  assign addr_latch = ale_r && (state_r == NMC_S_WLOW || state_r == NMC_S_WHIGH);
  assign write_strobe_n = state_r != NMC_S_WLOW;
  assign read_strobe_low = state_r != NMC_S_RLOW;
  assign io_oe_n = !(state_r == NMC_S_WLOW || state_r == NMC_S_WHIGH);
  assign io_out = io_out_r;

  // Capture read byte at end of strobe; 71h status bytes also give plane results
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_data_r <= '0;
      rsp_v_r <= 1'b0;
      plane_fail_r <= '0;
      st_valid_r <= 1'b0;
    end else begin
      rsp_v_r <= 1'b0;
      if ((state_r == NMC_S_RLOW && cnt_done)
          || (state_r == NMC_S_WAIT && state_nxt == NMC_S_IDLE)) begin
        rsp_v_r <= 1'b1;
        rsp_data_r <= (state_r == NMC_S_RLOW) ? io_in : rsp_data_r;
        // Plane bits count only when the status byte itself shows ready
        if (state_r == NMC_S_RLOW && mp_status_r && cmd_status_last) begin
          st_valid_r <= io_in[NMC_ST_READY];
          if (io_in[NMC_ST_READY]) plane_fail_r <= io_in[NMC_ST_PLANE_LO +: NMC_PLANES];
        end
      end
      if (take && !reject && is_cmd && !cmd_status) st_valid_r <= 1'b0;
    end
  end

  assign rsp_valid = rsp_v_r;
  assign rsp_data = rsp_data_r;
  assign refused = take && reject;
  assign plane_fail = plane_fail_r;
  assign status_ok_valid = st_valid_r;

  // Assertions
  property p_pwr_wait;
    @(posedge clk) disable iff (!nrst)
      $fell(chip_en_n) |-> $past(state_r) == NMC_S_PWR && $past(cnt_r) == '0;
  endproperty
  a_pwr_wait: assert property (p_pwr_wait) else $error("enable before power wait");

  property p_busy_refuse;
    @(posedge clk) disable iff (!nrst)
      (take && mp_busy_r && req_op == NMC_OP_ADDR) |-> refused ##1 state_r == NMC_S_IDLE;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("busy not refused");

  property p_dup_reset;
    @(posedge clk) disable iff (!nrst)
      (take && in_reset_r && is_cmd && cmd_reset) |-> refused;
  endproperty
  a_dup_reset: assert property (p_dup_reset) else $error("repeat reset sent");

  property p_erase_max;
    @(posedge clk) disable iff (!nrst) erase_cnt_r <= 3'(NMC_PLANES);
  endproperty
  a_erase_max: assert property (p_erase_max) else $error("too many erase setups");

  property p_wr_pulse;
    @(posedge clk) disable iff (!nrst)
      $fell(write_strobe_n) |-> !write_strobe_n [*8] ##1 write_strobe_n;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse width");

  property p_wait_ready;
    @(posedge clk) disable iff (!nrst)
      (state_r == NMC_S_WAIT && state_nxt == NMC_S_IDLE) |-> ready_busy_n ##1 rsp_valid;
  endproperty
  a_wait_ready: assert property (p_wait_ready) else $error("wait ended while busy");

  property p_valid_ready;
    @(posedge clk) disable iff (!nrst) $rose(st_valid_r) |-> $past(io_in[NMC_ST_READY], 1);
  endproperty
  a_valid_ready: assert property (p_valid_ready) else $error("results trusted while busy");

  property p_read_strobe;
    @(posedge clk) disable iff (!nrst)
      $fell(read_strobe_low) |-> io_oe_n throughout (!read_strobe_low [*8]);
  endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("driving during read");

  property p_lock;
    @(posedge clk) disable iff (!nrst)
      (take && !reject && locks_cmd) |=> mp_busy_r;
  endproperty
  a_lock: assert property (p_lock) else $error("program or erase left unlocked");

  property p_status_keeps_lock;
    @(posedge clk) disable iff (!nrst)
      (take && mp_busy_r && is_cmd && cmd_status) |=> mp_busy_r;
  endproperty
  a_status_keeps_lock: assert property (p_status_keeps_lock) else $error("lock lost");
endmodule : nmc_ctrl

// ---- nmc_ctrl_tb.sv ----
// Self-checking bench for the multi-plane flash host controller
`timescale 1ns/1ps
module nmc_ctrl_tb;
  import nmc_pkg::*;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
  localparam logic [7:0] DEVID = 8'h3c; // Arbitrary value
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  nmc_op_t req_op = NMC_OP_CMD;
  logic [7:0] req_data = 8'h00;
  logic [3:0] fail_mask = 4'h0;
  logic req_ready, rsp_valid, refused, status_ok_valid, init_done, chip_en_n, cmd_latch;
  logic addr_latch, write_strobe_n, read_strobe_low, io_oe_n, dev_oe, rb_n;
  logic [7:0] rsp_data, io_out, dev_q, got;
  logic [3:0] plane_fail;
  // Released lines show the inverted device byte, never the byte it would drive
  wire [7:0] io_bus = !io_oe_n ? io_out : dev_oe ? dev_q : ~dev_q;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  nmc_ctrl nmc_ctrl_i (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .refused(refused), .plane_fail(plane_fail), .status_ok_valid(status_ok_valid),
    .init_done(init_done), .chip_en_n(chip_en_n), .cmd_latch(cmd_latch),
    .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
    .read_strobe_low(read_strobe_low), .io_out(io_out), .io_oe_n(io_oe_n),
    .io_in(io_bus), .ready_busy_n(rb_n));
  nmc_dev_model #(.MAKER(MAKER), .DEVID(DEVID)) nmc_dev_model_i (.ce_n(chip_en_n),
    .cle(cmd_latch), .ale(addr_latch), .wr_n(write_strobe_n), .rd_n(read_strobe_low),
    .io(io_bus), .fail_mask(fail_mask), .dev_q(dev_q), .dev_oe(dev_oe), .rb_n(rb_n));
  initial begin
    forever #2 clk = ~clk;
  end
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask : chk1
  // One request, held until taken; reads and waits also collect the answer
  task automatic rq(input nmc_op_t op, input logic [7:0] d, input logic rf);
    int n;
    n = 0;
    req_op = op;
    req_data = d;
    req_valid = 1'b1;
    do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 4000);
    if (req_ready !== 1'b1) mismatches++;
    chk1(refused, rf);
    @(posedge clk);
    #1 req_valid = 1'b0;
    if (op == NMC_OP_RDATA || op == NMC_OP_WAIT) begin
      n = 0;
      while (rsp_valid !== 1'b1 && n < 4000) begin @(negedge clk); n++; end
      if (rsp_valid !== 1'b1) mismatches++;
      got = rsp_data;
    end
    // Let an edge pass so valid never falls and rises in one time step
    @(posedge clk);
    #1;
  endtask : rq
  task automatic addr4(input logic [1:0] p, input logic [7:0] row);
    rq(NMC_OP_ADDR, 8'h00, 1'b0);
    rq(NMC_OP_ADDR, {1'b0, p, 5'h01}, 1'b0);
    rq(NMC_OP_ADDR, row, 1'b0);
    rq(NMC_OP_ADDR, 8'h00, 1'b0);
  endtask : addr4
  task automatic rd_st(input logic [7:0] c, input logic [7:0] m, input logic [7:0] e);
    rq(NMC_OP_CMD, c, 1'b0);
    rq(NMC_OP_RDATA, 8'h00, 1'b0);
    chk8(got & m, e);
  endtask : rd_st
  task automatic t_power;
    repeat (2490) @(posedge clk);
    #1 chk1(init_done, 1'b0);
    repeat (30) @(posedge clk);
    #1 chk1(init_done, 1'b1);
  endtask : t_power
  task automatic t_id;
    rq(NMC_OP_CMD, NMC_CMD_READ_ID, 1'b0);
    rq(NMC_OP_ADDR, NMC_ID_ADDR, 1'b0);
    rq(NMC_OP_RDATA, 8'h00, 1'b0);
    chk8(got, MAKER);
    rq(NMC_OP_RDATA, 8'h00, 1'b0);
    chk8(got, DEVID);
    rq(NMC_OP_RDATA, 8'h00, 1'b0);
    rq(NMC_OP_RDATA, 8'h00, 1'b0);
    chk8(got, 8'hc0);
  endtask : t_id
  // Four blocks, one plane failing, extras refused while busy
  task automatic t_erase;
    fail_mask = 4'b0100;
    for (int p = 0; p < 4; p++) begin
      rq(NMC_OP_CMD, NMC_CMD_ERASE_SETUP, 1'b0);
      rq(NMC_OP_ADDR, {1'b0, 2'(p), 5'h00}, 1'b0);
      rq(NMC_OP_ADDR, 8'h01, 1'b0);
      rq(NMC_OP_ADDR, 8'h00, 1'b0);
    end
    rq(NMC_OP_CMD, NMC_CMD_ERASE_SETUP, 1'b1);
    rq(NMC_OP_CMD, NMC_CMD_ERASE_CONF, 1'b0);
    rd_st(NMC_CMD_STATUS, 8'h40, 8'h00);
    rq(NMC_OP_ADDR, 8'h00, 1'b1);
    rq(NMC_OP_CMD, NMC_CMD_READ_ID, 1'b1);
    rq(NMC_OP_WAIT, 8'h00, 1'b0);
    rd_st(NMC_CMD_STATUS_MP, 8'hdf, {2'b11, 1'b0, fail_mask, 1'b1});
    chk8({4'h0, plane_fail}, {4'h0, fail_mask});
    chk1(status_ok_valid, 1'b1);
    rd_st(NMC_CMD_STATUS, 8'hc1, 8'hc1);
  endtask : t_erase
  task automatic t_copy;
    fail_mask = 4'h0;
    for (int p = 0; p < 2; p++) begin
      rq(NMC_OP_CMD, p == 0 ? NMC_CMD_READ0 : NMC_CMD_READ_PLANE, 1'b0);
      addr4(2'(p * 3), 8'h02);
      rq(NMC_OP_WAIT, 8'h00, 1'b0);
    end
    for (int p = 0; p < 2; p++) begin
      rq(NMC_OP_CMD, NMC_CMD_COPY_IN, 1'b0);
      addr4(2'(p * 3), 8'h07);
      rq(NMC_OP_CMD, p == 1 ? NMC_CMD_PROG : NMC_CMD_DUMMY, 1'b0);
      rq(NMC_OP_WAIT, 8'h00, 1'b0);
    end
    rd_st(NMC_CMD_STATUS_MP, 8'hdf, 8'hc0);
  endtask : t_copy
  // Abort a failing erase, then a repeated reset
  task automatic t_reset;
    fail_mask = 4'hf;
    rq(NMC_OP_CMD, NMC_CMD_ERASE_SETUP, 1'b0);
    rq(NMC_OP_ADDR, 8'h20, 1'b0);
    rq(NMC_OP_ADDR, 8'h01, 1'b0);
    rq(NMC_OP_ADDR, 8'h00, 1'b0);
    rq(NMC_OP_CMD, NMC_CMD_ERASE_CONF, 1'b0);
    rq(NMC_OP_CMD, NMC_CMD_RESET, 1'b0);
    rq(NMC_OP_CMD, NMC_CMD_RESET, 1'b1);
    rq(NMC_OP_WAIT, 8'h00, 1'b0);
    rd_st(NMC_CMD_STATUS_MP, 8'hdf, 8'hc0);
    rq(NMC_OP_RDATA, 8'h00, 1'b0);
    chk8(got & 8'hdf, 8'hc0);
  endtask : t_reset
  initial begin
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    t_power();
    t_id();
    t_erase();
    t_copy();
    t_reset();
    wrap_up();
  end
endmodule : nmc_ctrl_tb

// ---- nmc_dev_model.sv ----
// Behavioural flash device answering the host controller's strobes
`timescale 1ns/1ps
module nmc_dev_model #(
  parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEVID = 8'h3c, // Arbitrary value
  parameter int BUSY_NS = 2000,        // Program or erase time
  parameter int DBSY_NS = 200          // Dummy, read and reset busy time
) (
  input wire logic ce_n,            // Chip enable
  input wire logic cle,             // Command latch
  input wire logic ale,             // Address latch
  input wire logic wr_n,            // Write strobe
  input wire logic rd_n,            // Read strobe
  input wire logic [7:0] io,        // Resolved I/O lines
  input wire logic [3:0] fail_mask, // Planes told to fail
  output logic [7:0] dev_q,         // Driven byte
  output logic dev_oe,              // Device drives I/O
  output logic rb_n                 // Ready/busy, pull-up level when released
);
  import nmc_pkg::*;
  logic [7:0] cmd_r = NMC_CMD_READ0;
  logic [3:0] pf_r = 4'h0;
  logic [2:0] nad = 3'h0;
  logic [1:0] idx = 2'h0;
  logic rdy = 1'b1;
  logic lock = 1'b0;
  logic in_rst = 1'b0;
  int tok = 0;
  wire st_mode = cmd_r == NMC_CMD_STATUS || cmd_r == NMC_CMD_STATUS_MP;
  wire [7:0] st_v = {1'b1, rdy, 1'b0, pf_r, |pf_r};
  wire [7:0] id_v = idx == 2'h0 ? MAKER : idx == 2'h1 ? DEVID : idx == 2'h2 ? 8'h00 : 8'hc0;
  // Status is live, so polling needs no strobe toggle
  assign dev_q = st_mode ? st_v : id_v;
  assign dev_oe = !ce_n && !rd_n;
  assign rb_n = rdy;
  // A newer operation or an abort makes older timers stale
  task automatic go(input int ns);
    int t;
    tok++;
    t = tok;
    rdy = 1'b0;
    fork begin #(ns); if (tok == t) begin rdy = 1'b1; lock = 1'b0; end end join_none
  endtask : go
  // Commands and addresses land on the rising write strobe
  always @(posedge wr_n) begin
    if (!ce_n && cle && (!lock || io == NMC_CMD_STATUS || io == NMC_CMD_STATUS_MP ||
        io == NMC_CMD_RESET)) begin
      nad = 3'h0;
      if (io != NMC_CMD_RESET) begin
        in_rst = 1'b0;
        cmd_r = io;
        idx = 2'h0;
        if (io == NMC_CMD_ERASE_CONF || io == NMC_CMD_PROG) begin
          pf_r = fail_mask;
          lock = 1'b1;
          go(BUSY_NS);
        end else if (io == NMC_CMD_DUMMY) go(DBSY_NS);
      end else if (!in_rst) begin
        in_rst = 1'b1;
        cmd_r = io;
        lock = 1'b0;
        pf_r = 4'h0;
        go(DBSY_NS);
      end
    end else if (!ce_n && ale && !lock) begin
      nad = nad + 3'h1;
      if (nad == NMC_ADDR_FULL && (cmd_r == NMC_CMD_READ0 || cmd_r == NMC_CMD_READ_PLANE))
        go(DBSY_NS);
    end
  end
  // Identification bytes advance per read cycle
  always @(posedge rd_n) if (!ce_n && cmd_r == NMC_CMD_READ_ID) idx = idx + 2'h1;
endmodule : nmc_dev_model

// ---- nmc_pkg.sv ----
// Constants for the host-side controller of a multi-plane NAND flash
package nmc_pkg;
  localparam logic [7:0] NMC_CMD_READ0 = 8'h00;
  localparam logic [7:0] NMC_CMD_READ_PLANE = 8'h03;
  localparam logic [7:0] NMC_CMD_PROG = 8'h10;
  localparam logic [7:0] NMC_CMD_DUMMY = 8'h11;
  localparam logic [7:0] NMC_CMD_READ2 = 8'h50;
  localparam logic [7:0] NMC_CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] NMC_CMD_STATUS = 8'h70;
  localparam logic [7:0] NMC_CMD_STATUS_MP = 8'h71;
  localparam logic [7:0] NMC_CMD_COPY_IN = 8'h8a;
  localparam logic [7:0] NMC_CMD_READ_ID = 8'h90;
  localparam logic [7:0] NMC_CMD_ERASE_CONF = 8'hd0;
  localparam logic [7:0] NMC_CMD_RESET = 8'hff;
  localparam logic [7:0] NMC_ID_ADDR = 8'h00;
  localparam logic [7:0] NMC_STATUS_RESET = 8'hc0;
  // Status bit positions
  localparam int NMC_ST_FAIL = 0;
  localparam int NMC_ST_PLANE_LO = 1;
  localparam int NMC_ST_READY = 6;
  localparam int NMC_ST_WP_N = 7;
  localparam int NMC_PLANES = 4;
  localparam int NMC_ID_BYTES = 4;
  // Plane select bits within the row address (A14, A15 in second address byte)
  localparam int NMC_PLANE_LSB = 14;
  // Address cycles
  localparam logic [2:0] NMC_ADDR_FULL = 3'h4;
  localparam logic [2:0] NMC_ADDR_BLOCK = 3'h3;
  localparam logic [2:0] NMC_ADDR_ID = 3'h1;
  // Timing
  localparam int NMC_CLK_NS = 4;
  localparam int NMC_POWERUP_US = 10;
  localparam int NMC_POWERUP_CYC = (NMC_POWERUP_US * 1000 + NMC_CLK_NS - 1) / NMC_CLK_NS;
  localparam int NMC_STROBE_CYC = 8;   // Strobe low and high width, 32 ns each
  localparam int NMC_BUSY_LAT_CYC = 32; // Wait before trusting ready/busy
  // Command kinds taken at the user port
  typedef enum logic [3:0] {
    NMC_OP_CMD = 4'h0,    // One command cycle
    NMC_OP_ADDR = 4'h1,   // One address cycle
    NMC_OP_WDATA = 4'h2,  // One data write cycle
    NMC_OP_RDATA = 4'h3,  // One data read cycle
    NMC_OP_WAIT = 4'h4    // Wait for ready
  } nmc_op_t;
endpackage : nmc_pkg
